// ===== inc/sbm_pkg.sv
/*
  Shared constants and types for the burst SRAM write-masking block.
  Assumes a single 50 MHz system clock; all pins are sampled as synchronous inputs.
*/
package sbm_pkg;
  localparam int ADDR_W   = 4;            // Loaded address width
  localparam int LOC_W    = ADDR_W + 1;   // Array index width
  localparam int DATA_W   = 36;           // Widest organisation
  localparam int MASK_W   = 4;            // Lane selects per beat
  localparam int WORD_W   = LOC_W + MASK_W + DATA_W;
  localparam int FIFO_DEPTH = 16;
  localparam int ARRAY_DEPTH = 32;

  // Field positions inside a queued beat
  localparam int DATA_LSB = 0;
  localparam int MASK_LSB = DATA_W;
  localparam int LOC_LSB  = DATA_W + MASK_W;

  // Values after reset
  localparam logic [DATA_W-1:0] DATA_RST = 36'h0_0000_0000;
  localparam logic [ADDR_W-1:0] ADDR_RST = 4'h0;

  // Organisations, chosen by strap pins
  typedef enum logic [1:0] {
    SBM_ORG_X8,
    SBM_ORG_X9,
    SBM_ORG_X18,
    SBM_ORG_X36
  } sbm_org_t;

  typedef enum {
    SBM_W_IDLE,
    SBM_W_BEAT1
  } sbm_wstate_t;

  typedef enum {
    SBM_R_IDLE,
    SBM_R_WAIT,
    SBM_R_BEAT1,
    SBM_R_END
  } sbm_rstate_t;
endpackage

// ===== inc/sbm_if.sv
/*
  Valid/ready carrier between the block's front end and its write queue.
  Assumes both ends run on the same clock.
*/
interface sbm_if #(
  parameter int W = 8
);
  logic         in_valid;
  logic         in_ready;
  logic [W-1:0] in_data;
  logic         out_valid;
  logic         out_ready;
  logic [W-1:0] out_data;

  modport user_mp (
    output in_valid,
    output in_data,
    output out_ready,
    input  in_ready,
    input  out_valid,
    input  out_data
  );

  modport fifo_mp (
    input  in_valid,
    input  in_data,
    input  out_ready,
    output in_ready,
    output out_valid,
    output out_data
  );
endinterface

// ===== verilog/sbm_fifo.sv
/*
  Flip-flop FIFO for queued write beats.
  Assumes one clock and a synchronous active-low reset; in_ready promises
  room for a full two-beat burst, but not for a loaded burst not yet pushed, so a back-to-back write can have beats dropped.
*/
module sbm_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  wire logic mclk_i,
  input  wire logic reset_n_i,
  sbm_if.fifo_mp    q
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = PW + 1;
  localparam logic [CW-1:0] ROOM_LIMIT = CW'(DEPTH - 2);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [PW-1:0]    wr_ptr_reg;
  logic [PW-1:0]    rd_ptr_reg;
  logic [CW-1:0]    count_reg;
  logic [CW-1:0]    count_next;
  logic             ready_reg;
  logic             push;
  logic             pop;

  // Honest full: a push with no room is dropped rather than corrupting data
  assign push       = q.in_valid && (count_reg != CW'(DEPTH));
  assign pop        = q.out_ready && (count_reg != '0);
  assign count_next = count_reg + CW'(push) - CW'(pop);
  assign q.out_valid = (count_reg != '0);
  assign q.out_data  = mem_reg[rd_ptr_reg];
  assign q.in_ready  = ready_reg;

  // Storage
  always_ff @(posedge mclk_i) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= q.in_data;
    end
  end

  // Pointers, occupancy and room for one more burst
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
      ready_reg  <= 1'b0;
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + PW'(1);
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + PW'(1);
      end
      count_reg <= count_next;
      ready_reg <= (count_next <= ROOM_LIMIT);
    end
  end
endmodule

// ===== verilog/sbm_top.sv
/*
  Burst SRAM core with per-beat byte and nibble write masking.
  Assumes the memory controller's clocks and strobes are synchronous
  level inputs sampled by mclk_i, at least two mclk cycles per phase.
*/
module sbm_top (
  input  wire logic                        mclk_i,
  input  wire logic                        reset_n_i,
  input  wire logic                        kclk_i,
  input  wire logic                        kclk_n_i,
  input  wire logic                        cclk_i,
  input  wire logic                        cclk_n_i,
  input  wire logic [1:0]                  org_i,
  input  wire logic                        address_load_n_i,
  input  wire logic                        read_sel_i,
  input  wire logic [sbm_pkg::ADDR_W-1:0]  addr_i,
  input  wire logic [sbm_pkg::MASK_W-1:0]  byte_mask_n_i,
  input  wire logic [sbm_pkg::DATA_W-1:0]  dq_i,
  output logic      [sbm_pkg::DATA_W-1:0]  dq_o,
  output logic                             dq_oe_o,
  output logic                             wr_ready_o
);
  sbm_if #(.W(sbm_pkg::WORD_W)) wq ();

  sbm_pkg::sbm_org_t               org_reg;
  logic                            single_clk_reg;
  logic                            strap_done_reg;
  logic                            k_reg;
  logic                            kn_reg;
  logic                            c_reg;
  logic                            cn_reg;
  logic                            k_rise;
  logic                            kn_rise;
  logic                            lc_rise;
  logic                            lcn_rise;
  logic                            wr_load;
  logic                            rd_load;
  sbm_pkg::sbm_wstate_t            wstate_reg;
  sbm_pkg::sbm_rstate_t            rstate_reg;
  logic                            wpend_reg;
  logic [sbm_pkg::ADDR_W-1:0]      wpend_addr_reg;
  logic [sbm_pkg::ADDR_W-1:0]      wcur_addr_reg;
  logic [sbm_pkg::ADDR_W-1:0]      raddr_reg;
  logic                            push_reg;
  logic [sbm_pkg::WORD_W-1:0]      push_word_reg;
  logic [sbm_pkg::DATA_W-1:0]      array_reg [sbm_pkg::ARRAY_DEPTH];
  logic [sbm_pkg::LOC_W-1:0]       pop_loc;
  logic [sbm_pkg::DATA_W-1:0]      pop_data;
  logic [sbm_pkg::DATA_W-1:0]      pop_we;

  // Array location of a beat: narrow parts append the beat number,
  // wide parts toggle the low address bit as the burst counter does
  function automatic logic [sbm_pkg::LOC_W-1:0] beat_loc(
    input sbm_pkg::sbm_org_t        org,
    input logic [sbm_pkg::ADDR_W-1:0] a,
    input logic                     beat
  );
    logic [sbm_pkg::LOC_W-1:0] loc;
    if (org == sbm_pkg::SBM_ORG_X8 || org == sbm_pkg::SBM_ORG_X9) begin
      loc = {a, beat};
    end else begin
      loc = {1'b0, a[sbm_pkg::ADDR_W-1:1], a[0] ^ beat};
    end
    return loc;
  endfunction

  // Per-bit write enables from the active-low lane selects
  function automatic logic [sbm_pkg::DATA_W-1:0] lane_we(
    input sbm_pkg::sbm_org_t          org,
    input logic [sbm_pkg::MASK_W-1:0] m_n
  );
    logic [sbm_pkg::DATA_W-1:0] we;
    we = '0;
    case (org)
      sbm_pkg::SBM_ORG_X8: begin
        we[3:0] = {4{~m_n[0]}};
        we[7:4] = {4{~m_n[1]}};
      end
      sbm_pkg::SBM_ORG_X9: begin
        we[8:0] = {9{~m_n[0]}};
      end
      sbm_pkg::SBM_ORG_X18: begin
        we[8:0]  = {9{~m_n[0]}};
        we[17:9] = {9{~m_n[1]}};
      end
      default: begin
        for (int i = 0; i < sbm_pkg::MASK_W; i++) begin
          we[i*9 +: 9] = {9{~m_n[i]}};
        end
      end
    endcase
    return we;
  endfunction

  // Straps are caught on the first clock after reset; they cannot change later
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      org_reg        <= sbm_pkg::SBM_ORG_X36;
      single_clk_reg <= 1'b0;
      strap_done_reg <= 1'b0;
    end else if (!strap_done_reg) begin
      org_reg        <= sbm_pkg::sbm_org_t'(org_i);
      single_clk_reg <= cclk_i && cclk_n_i;
      strap_done_reg <= 1'b1;
    end
  end

  // Edge detection on the sampled clock pins; idle-high clocks give no edge
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      k_reg  <= 1'b1;
      kn_reg <= 1'b1;
      c_reg  <= 1'b1;
      cn_reg <= 1'b1;
    end else begin
      k_reg  <= kclk_i;
      kn_reg <= kclk_n_i;
      c_reg  <= cclk_i;
      cn_reg <= cclk_n_i;
    end
  end

  assign k_rise   = strap_done_reg && kclk_i && !k_reg;
  assign kn_rise  = strap_done_reg && kclk_n_i && !kn_reg;
  assign lc_rise  = single_clk_reg ? k_rise : (strap_done_reg && cclk_i && !c_reg);
  assign lcn_rise = single_clk_reg ? kn_rise : (strap_done_reg && cclk_n_i && !cn_reg);
  assign wr_load  = k_rise && !address_load_n_i && !read_sel_i && wr_ready_o;
  assign rd_load  = k_rise && !address_load_n_i && read_sel_i && (rstate_reg == sbm_pkg::SBM_R_IDLE);

  // Write sequencer: address loaded at t, beat one at t+1 K, beat two at t+1 K#.
  // A pending slot lets a new write load on the same K edge as a beat.
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      wstate_reg     <= sbm_pkg::SBM_W_IDLE;
      wpend_reg      <= 1'b0;
      wpend_addr_reg <= sbm_pkg::ADDR_RST;
      wcur_addr_reg  <= sbm_pkg::ADDR_RST;
      push_reg       <= 1'b0;
      push_word_reg  <= '0;
    end else begin
      push_reg <= 1'b0;
      if (k_rise) begin
        wpend_reg      <= wr_load;
        wpend_addr_reg <= addr_i;
        if (wpend_reg) begin
          // Mask travels with its own beat only
          push_reg      <= 1'b1;
          push_word_reg <= {beat_loc(org_reg, wpend_addr_reg, 1'b0), byte_mask_n_i, dq_i};
          wcur_addr_reg <= wpend_addr_reg;
          wstate_reg    <= sbm_pkg::SBM_W_BEAT1;
        end
      end else if (kn_rise && wstate_reg == sbm_pkg::SBM_W_BEAT1) begin
        push_reg      <= 1'b1;
        push_word_reg <= {beat_loc(org_reg, wcur_addr_reg, 1'b1), byte_mask_n_i, dq_i};
        wstate_reg    <= sbm_pkg::SBM_W_IDLE;
      end
    end
  end

  assign wq.in_valid  = push_reg;
  assign wq.in_data   = push_word_reg;
  // Reads own the array while a burst is on the pins, so commits wait;
  // this is what lets the queue really fill under heavy read traffic
  assign wq.out_ready = (rstate_reg == sbm_pkg::SBM_R_IDLE);

  sbm_fifo #(
    .WIDTH (sbm_pkg::WORD_W),
    .DEPTH (sbm_pkg::FIFO_DEPTH)
  ) u_fifo (
    .mclk_i    (mclk_i),
    .reset_n_i (reset_n_i),
    .q         (wq)
  );

  assign pop_loc  = wq.out_data[sbm_pkg::LOC_LSB +: sbm_pkg::LOC_W];
  assign pop_data = wq.out_data[sbm_pkg::DATA_LSB +: sbm_pkg::DATA_W];
  assign pop_we   = lane_we(org_reg, wq.out_data[sbm_pkg::MASK_LSB +: sbm_pkg::MASK_W]);

  // Commit: only enabled lanes change; all-high masks leave the word alone
  always_ff @(posedge mclk_i) begin
    if (wq.out_valid && wq.out_ready) begin
      array_reg[pop_loc] <= (array_reg[pop_loc] & ~pop_we) | (pop_data & pop_we);
    end
  end

  // Read burst: first word on the launch-clock-bar edge, second on the next
  // launch-clock edge, outputs released on the following launch-clock edge
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      rstate_reg <= sbm_pkg::SBM_R_IDLE;
      raddr_reg  <= sbm_pkg::ADDR_RST;
      dq_o       <= sbm_pkg::DATA_RST;
      dq_oe_o    <= 1'b0;
    end else begin
      case (rstate_reg)
        sbm_pkg::SBM_R_IDLE: begin
          if (rd_load) begin
            raddr_reg  <= addr_i;
            rstate_reg <= sbm_pkg::SBM_R_WAIT;
          end
        end
        sbm_pkg::SBM_R_WAIT: begin
          if (lcn_rise) begin
            dq_o       <= array_reg[beat_loc(org_reg, raddr_reg, 1'b0)];
            dq_oe_o    <= 1'b1;
            rstate_reg <= sbm_pkg::SBM_R_BEAT1;
          end
        end
        sbm_pkg::SBM_R_BEAT1: begin
          if (lc_rise) begin
            dq_o       <= array_reg[beat_loc(org_reg, raddr_reg, 1'b1)];
            rstate_reg <= sbm_pkg::SBM_R_END;
          end
        end
        default: begin
          if (lc_rise) begin
            dq_oe_o    <= 1'b0;
            rstate_reg <= sbm_pkg::SBM_R_IDLE;
          end
        end
      endcase
    end
  end

  // Room for a whole burst, the queue's ready flop registered once more
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      wr_ready_o <= 1'b0;
    end else begin
      wr_ready_o <= wq.in_ready;
    end
  end
endmodule

// ===== verification/sbm_top_sva.sv
/*
  Pin checker for the burst SRAM write-masking core.
  Assumes it is bound to sbm_top and sees one clock with a synchronous active-low reset.
*/
module sbm_top_sva (
  input wire logic                       mclk_i,
  input wire logic                       reset_n_i,
  input wire logic                       kclk_i,
  input wire logic                       kclk_n_i,
  input wire logic                       cclk_i,
  input wire logic                       cclk_n_i,
  input wire logic                       address_load_n_i,
  input wire logic                       read_sel_i,
  input wire logic [sbm_pkg::DATA_W-1:0] dq_o,
  input wire logic                       dq_oe_o,
  input wire logic                       wr_ready_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic       prev_rst_reg, single_reg, k_reg, oe_reg, rd_pend_reg, lp_reg, ln_reg;
  logic [1:0] pr_reg, nr_reg;
  wire        krise = kclk_i && !k_reg;
  wire        lp    = single_reg ? kclk_i : cclk_i;
  wire        ln    = single_reg ? kclk_n_i : cclk_n_i;

  // Strap caught once at release, as the core does
  always_ff @(posedge mclk_i) begin
    prev_rst_reg <= reset_n_i;
    if (reset_n_i && !prev_rst_reg) single_reg <= cclk_i && cclk_n_i;
  end
  // Recent launch rises; two bits so either output alignment is accepted
  always_ff @(posedge mclk_i) begin
    lp_reg <= lp;
    ln_reg <= ln;
    pr_reg <= {pr_reg[0], lp && !lp_reg};
    nr_reg <= {nr_reg[0], ln && !ln_reg};
  end
  // Read bookkeeping; K resets high so release makes no false rise
  always_ff @(posedge mclk_i) begin
    k_reg  <= reset_n_i ? kclk_i : 1'b1;
    oe_reg <= dq_oe_o;
    if (!reset_n_i || (oe_reg && !dq_oe_o)) rd_pend_reg <= 1'b0;
    else if (krise && !address_load_n_i && read_sel_i) rd_pend_reg <= 1'b1;
  end

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!reset_n_i);

  a_reset_quiet: assert property (
    $rose(reset_n_i) |-> !dq_oe_o && !wr_ready_o && dq_o == sbm_pkg::DATA_RST)
    else $error("outputs active at reset release");
  a_ready_up: assert property (
    $rose(reset_n_i) |-> ##[1:3] wr_ready_o)
    else $error("write ready late after reset");
  a_oe_rise_edge: assert property (
    $rose(dq_oe_o) |-> |nr_reg)
    else $error("drive began without negative launch edge");
  a_oe_fall_edge: assert property (
    $fell(dq_oe_o) |-> |pr_reg)
    else $error("drive ended without positive launch edge");
  a_word_change: assert property (
    dq_oe_o && $past(dq_oe_o) && $changed(dq_o) |-> |pr_reg)
    else $error("read word changed off a launch edge");
  a_oe_needs_read: assert property (
    dq_oe_o |-> rd_pend_reg)
    else $error("data driven with no read loaded");
  a_write_silent: assert property (
    krise && !address_load_n_i && !read_sel_i && !rd_pend_reg |=> !dq_oe_o [*4])
    else $error("write load drove the data bus");
  a_nop_silent: assert property (
    krise && address_load_n_i && !rd_pend_reg |=> !dq_oe_o)
    else $error("no-operation drove the data bus");

  c_write_load: cover property (krise && !address_load_n_i && !read_sel_i);
  c_read_start: cover property ($rose(dq_oe_o));
  c_read_end: cover property ($fell(dq_oe_o));
endmodule

// ===== verification/sbm_ctl_model.sv
/*
  Memory-controller model driving the SRAM pins.
  Assumes mclk_i samples every pin; each clock phase is held two cycles.
*/
module sbm_ctl_model (
  input  wire logic                       mclk_i,
  input  wire logic [sbm_pkg::DATA_W-1:0] dq_i,
  input  wire logic                       dq_oe_i,
  input  wire logic                       wr_ready_i,
  output logic                            kclk_o,
  output logic                            kclk_n_o,
  output logic                            cclk_o,
  output logic                            cclk_n_o,
  output logic                            load_n_o,
  output logic                            read_sel_o,
  output logic [sbm_pkg::ADDR_W-1:0]      addr_o,
  output logic [sbm_pkg::MASK_W-1:0]      mask_n_o,
  output logic [sbm_pkg::DATA_W-1:0]      dq_o
);
  timeunit 1ns;
  timeprecision 1ns;
  bit single;

  // Idle pins; C# low selects the two-clock mode at release
  task automatic setup(input bit s);
    single = s;
    kclk_o <= 1'b1;
    kclk_n_o <= 1'b1;
    cclk_o <= 1'b1;
    cclk_n_o <= s;
    load_n_o <= 1'b1;
    read_sel_o <= 1'b0;
    addr_o <= 4'h0;
    mask_n_o <= 4'hF;
    dq_o <= 36'h0_0000_0000;
  endtask
  // One rise: two cycles low, two high, so no phase is missed
  task automatic pulse(input int c);
    for (int i = 0; i < 4; i++) begin
      @(posedge mclk_i);
      case (c)
        0: kclk_o <= i > 1;
        1: kclk_n_o <= i > 1;
        2: cclk_o <= i > 1;
        default: cclk_n_o <= i > 1;
      endcase
    end
  endtask
  // Address phase at a K rise, cycle t
  task automatic load(input logic [3:0] a, input logic rd);
    load_n_o <= 1'b0;
    read_sel_o <= rd;
    addr_o <= a;
    pulse(0);
    load_n_o <= 1'b1;
    addr_o <= ~a;
  endtask
  // Write burst; waits for room, beats at t+1 on K and K#
  task automatic wr(input logic [3:0] a, input logic [35:0] d0, d1, input logic [3:0] m0, m1, output bit ok);
    int n;
    n = 0;
    do begin
      @(posedge mclk_i);
      #1;
      n++;
    end while (wr_ready_i !== 1'b1 && n < 40);
    ok = n < 40;
    @(posedge mclk_i);
    load(a, 1'b0);
    dq_o <= d0;
    mask_n_o <= m0;
    pulse(0);
    dq_o <= d1;
    mask_n_o <= m1;
    pulse(1);
    dq_o <= ~d1; // Released bus shows the inverse, not a stale value
    mask_n_o <= ~m1;
  endtask
  // Two writes back to back: the second load shares the first write's beat-one K rise
  task automatic wr_pair(input logic [3:0] a, b, input logic [35:0] d0, d1, e0, e1);
    load_n_o <= 1'b0;
    read_sel_o <= 1'b0;
    addr_o <= a;
    mask_n_o <= 4'h0;
    pulse(0);
    addr_o <= b;
    dq_o <= d0;
    pulse(0);
    load_n_o <= 1'b1;
    addr_o <= ~b;
    dq_o <= d1;
    pulse(1);
    dq_o <= e0;
    pulse(0);
    dq_o <= e1;
    pulse(1);
    dq_o <= ~e1;
    mask_n_o <= 4'hF;
  endtask
  // Read burst; sample each word one cycle after its launch edge
  task automatic rd(input logic [3:0] a, output logic [35:0] w0, w1, output logic oe0, oe1);
    load(a, 1'b1);
    pulse(single ? 1 : 3);
    @(posedge mclk_i);
    #1;
    w0 = dq_i;
    oe0 = dq_oe_i;
    pulse(single ? 0 : 2);
    @(posedge mclk_i);
    #1;
    w1 = dq_i;
    pulse(single ? 0 : 2);
    @(posedge mclk_i);
    #1;
    oe1 = dq_oe_i;
  endtask
endmodule

// ===== verification/tb_top.sv
/*
  Self-checking bench for the burst SRAM write-masking core.
  Assumes the package, design, checker and controller model are compiled first.
*/
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic                       mclk;
  logic                       rst_n = 1'b0;
  logic [1:0]                 org   = 2'h0;
  logic                       kc, kcn, cc, ccn, load_n, rsel, oe, rdy;
  logic [sbm_pkg::ADDR_W-1:0] addr;
  logic [sbm_pkg::MASK_W-1:0] msk;
  logic [sbm_pkg::DATA_W-1:0] din, dout;
  logic [35:0]                mem [32];
  int                         error_cnt = 0;
  int                         n_tests   = 0;

  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  sbm_top u_dut (.mclk_i(mclk), .reset_n_i(rst_n), .kclk_i(kc), .kclk_n_i(kcn), .cclk_i(cc), .cclk_n_i(ccn),
    .org_i(org), .address_load_n_i(load_n), .read_sel_i(rsel), .addr_i(addr), .byte_mask_n_i(msk), .dq_i(din),
    .dq_o(dout), .dq_oe_o(oe), .wr_ready_o(rdy));
  sbm_ctl_model u_ctl (.mclk_i(mclk), .dq_i(dout), .dq_oe_i(oe), .wr_ready_i(rdy), .kclk_o(kc), .kclk_n_o(kcn),
    .cclk_o(cc), .cclk_n_o(ccn), .load_n_o(load_n), .read_sel_o(rsel), .addr_o(addr), .mask_n_o(msk), .dq_o(din));

  task automatic check(string what, logic [35:0] seen, logic [35:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // Lane merge: nibbles for x8, nine-bit lanes otherwise; high mask keeps old bits
  function automatic logic [35:0] merge(int o, logic [35:0] old, logic [35:0] d, logic [3:0] m);
    int lw;
    int nl;
    lw = (o == 0) ? 4 : 9;
    nl = (o == 3) ? 4 : (o == 1) ? 1 : 2;
    for (int b = 0; b < 36; b++)
      if (b / lw < nl && !m[b / lw]) old[b] = d[b];
    return old;
  endfunction

  // Narrow orgs append the beat; wide orgs toggle the burst bit
  function automatic logic [4:0] loc(int o, logic [3:0] a, logic b);
    return (o < 2) ? {a, b} : {1'b0, a ^ {3'h0, b}};
  endfunction

  task automatic wr_exp(int o, logic [3:0] a, logic [35:0] d0, d1, logic [3:0] m0, m1);
    bit ok;
    u_ctl.wr(a, d0, d1, m0, m1, ok);
    mem[loc(o, a, 1'b0)] = merge(o, mem[loc(o, a, 1'b0)], d0, m0);
    mem[loc(o, a, 1'b1)] = merge(o, mem[loc(o, a, 1'b1)], d1, m1);
    if (!ok) begin
      error_cnt++;
      complete_run();
    end
  endtask

  // Per organisation: full, half-masked and empty-mask beats at an odd address, then read back
  task automatic run_org(int o, bit s);
    logic [35:0] w0, w1, wm;
    logic        oe0, oe1;
    u_ctl.setup(s);
    org <= o[1:0];
    rst_n <= 1'b0;
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (4) @(posedge mclk);
    #1;
    check("oe_idle", oe, 1'b0);
    wr_exp(o, 4'h5, 36'hA_5A5A_5A5A, 36'h5_C3C3_C3C3, 4'h0, 4'h0);
    wr_exp(o, 4'h5, 36'hF_0F0F_0F0F, 36'h3_6969_1E1E, 4'hA, 4'hF);
    wr_exp(o, 4'h5, 36'hC_F00F_33CC, 36'h6_1234_5678, 4'hF, 4'h5);
    repeat (8) @(posedge mclk); // Queue drains; reads do not bypass it
    u_ctl.rd(4'h5, w0, w1, oe0, oe1);
    wm = ~(36'hF_FFFF_FFFF << ((o == 0) ? 8 : (o == 1) ? 9 : (o == 2) ? 18 : 36));
    check("word0", w0 & wm, mem[loc(o, 4'h5, 1'b0)] & wm);
    check("word1", w1 & wm, mem[loc(o, 4'h5, 1'b1)] & wm);
    check("oe_read", oe0, 1'b1);
    check("oe_done", oe1, 1'b0);
    $display("test org %0d single %0d done", o, s);
  endtask

  // Back-to-back x36 writes: the pending slot must carry the second load, then both read back
  task automatic run_pair;
    logic [35:0] w0, w1;
    logic        oe0, oe1;
    @(posedge mclk);
    #1;
    check("ready_pair", rdy, 1'b1);
    @(posedge mclk);
    u_ctl.wr_pair(4'h2, 4'h9, 36'h1_2345_6789, 36'h9_8765_4321, 36'hE_DCBA_9876, 36'h0_F1E2_D3C4);
    repeat (8) @(posedge mclk);
    u_ctl.rd(4'h2, w0, w1, oe0, oe1);
    check("pair_a0", w0, 36'h1_2345_6789);
    check("pair_a1", w1, 36'h9_8765_4321);
    @(posedge mclk);
    u_ctl.rd(4'h9, w0, w1, oe0, oe1);
    check("pair_b0", w0, 36'hE_DCBA_9876);
    check("pair_b1", w1, 36'h0_F1E2_D3C4);
    check("pair_oe", {oe0, oe1}, 2'h2);
    $display("test pair done");
  endtask

  // Single-clock runs for every org, then two-clock x36 with a back-to-back pair
  initial begin
    for (int o = 0; o < 4; o++) run_org(o, 1'b1);
    run_org(3, 1'b0);
    run_pair();
    complete_run();
  end
endmodule

bind sbm_top sbm_top_sva u_sva (.*);
